// ### logic/lcs_controller.sv
// Purpose: bus controller end: software registers, tx fifo, bit engine
// Assumes: software polls status; one transfer at a time
// Notes: read data is paced by software, scl is held low meanwhile
`timescale 1ns/100ps
`include "lcs_defines.svh"
module lcs_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 4
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = $clog2(DEPTH + 1);
  logic [WIDTH-1:0] mem [0:DEPTH-1];
  logic [AW-1:0] wp_q, wp_d, rp_q, rp_d;
  logic [CW-1:0] cnt_q, cnt_d;
  logic space_q, space_d;
  logic push, pop;

  assign push = in_valid && space_q;
  assign pop = out_ready && out_valid;

  always_comb begin
    wp_d = push ? ((wp_q == AW'(DEPTH - 1)) ? '0 : wp_q + AW'(1)) : wp_q;
    rp_d = pop ? ((rp_q == AW'(DEPTH - 1)) ? '0 : rp_q + AW'(1)) : rp_q;
    cnt_d = cnt_q + CW'(push) - CW'(pop);
    space_d = cnt_d != CW'(DEPTH);
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      wp_q <= '0;
      rp_q <= '0;
      cnt_q <= '0;
      space_q <= 1'b1;
    end else begin
      wp_q <= wp_d;
      rp_q <= rp_d;
      cnt_q <= cnt_d;
      space_q <= space_d;
    end
  end

  always_ff @(posedge clk) begin
    if (push) begin
      mem[wp_q] <= in_data;
    end
  end

  assign in_ready = space_q;
  assign out_valid = cnt_q != '0;
  assign out_data = mem[rp_q];
endmodule : lcs_fifo

////////////////////////////////////////////////////////////////////////////////

module lcs_controller
  import lcs_pkg::*;
#(
  parameter int POR_CYC = `LCS_WAIT_CYC
) (
  input wire logic clk,
  input wire logic rst,
  lcs_if.ctl bus,
  input wire logic [3:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [31:0] rdata,
  output logic tx_ready
);
  lcs_ctl_state_type state_q, state_d;
  logic [17:0] por_q, por_d;
  logic por_done_q, por_done_d;
  logic first_q, first_d;
  logic [7:0] qcnt_q, qcnt_d;
  logic [1:0] ph_q, ph_d;
  logic [8:0] sh_q, sh_d, rx_q, rx_d;
  logic [3:0] bit_q, bit_d;
  logic rdx_q, rdx_d, addrb_q, addrb_d, nack_q, nack_d, rxv_q, rxv_d;
  logic [4:0] len_q, len_d, len_next;
  logic [7:0] rxd_q, rxd_d;
  logic scl_oe_q, scl_oe_d, sda_oe_q, sda_oe_d;
  logic [31:0] rdata_q, rdata_d;
  logic tick, fifo_valid, fifo_pop, go_wr, go_rd;
  logic [7:0] fifo_data;

  lcs_fifo #(.WIDTH(8), .DEPTH(4)) u_fifo (
    .clk(clk),
    .rst(rst),
    .in_valid(wr && addr == `LCS_REG_TXD),
    .in_ready(tx_ready),
    .in_data(wdata[7:0]),
    .out_valid(fifo_valid),
    .out_ready(fifo_pop),
    .out_data(fifo_data)
  );

  assign tick = qcnt_q == 8'(`LCS_QTR_CYC - 1);
  assign go_wr = wr && addr == `LCS_REG_CTRL && wdata[`LCS_CTRL_GO_WR];
  assign go_rd = wr && addr == `LCS_REG_CTRL && wdata[`LCS_CTRL_GO_RD];
  assign len_next = len_q - 5'h01;

  always_comb begin
    state_d = state_q;
    por_d = por_done_q ? por_q : por_q + 18'h00001;
    por_done_d = por_done_q || por_q == 18'(POR_CYC - 1); // RQ16 RQ1
    first_d = first_q;
    qcnt_d = (state_q == CS_IDLE || tick) ? 8'h00 : qcnt_q + 8'h01;
    ph_d = (state_q != CS_IDLE && tick) ? ph_q + 2'h1 : ph_q;
    sh_d = sh_q;
    rx_d = rx_q;
    bit_d = bit_q;
    rdx_d = rdx_q;
    addrb_d = addrb_q;
    nack_d = nack_q;
    rxv_d = rxv_q;
    len_d = len_q;
    rxd_d = rxd_q;
    scl_oe_d = scl_oe_q;
    sda_oe_d = sda_oe_q;
    fifo_pop = 1'b0;
    rdata_d = 32'h00000000;
    if (rd) begin
      unique case (addr)
        `LCS_REG_STAT: rdata_d = {27'h0, por_done_q, tx_ready, rxv_q, nack_q,
                                  state_q != CS_IDLE};
        `LCS_REG_RXD: begin
          rdata_d = {24'h0, rxd_q};
          rxv_d = 1'b0;
        end
        default: rdata_d = 32'h00000000;
      endcase
    end
    unique case (state_q)
      CS_IDLE: begin
        ph_d = 2'h0;
        if ((go_wr || go_rd) && por_done_q) begin
          rdx_d = go_rd && !go_wr;
          len_d = (wdata[`LCS_CTRL_LEN_MSB:`LCS_CTRL_LEN_LSB] == 5'h00) ? 5'h01 :
                  wdata[`LCS_CTRL_LEN_MSB:`LCS_CTRL_LEN_LSB];
          sh_d = {`LCS_DEV_ID, go_rd && !go_wr, 1'b1}; // RQ2 RQ11
          addrb_d = 1'b1;
          nack_d = 1'b0;
          bit_d = 4'h0;
          state_d = first_q ? CS_PSTOP : CS_START; // RQ1
        end
      end
      CS_PSTOP: begin
        if (tick) begin
          unique case (ph_q)
            2'h0: scl_oe_d = 1'b1;
            2'h1: sda_oe_d = 1'b1;
            2'h2: scl_oe_d = 1'b0;
            default: begin
              sda_oe_d = 1'b0; // RQ1
              first_d = 1'b0;
              state_d = CS_START;
            end
          endcase
        end
      end
      CS_START: begin
        if (tick && ph_q == 2'h0) sda_oe_d = 1'b1;
        if (tick && ph_q == 2'h3) begin
          scl_oe_d = 1'b1;
          state_d = CS_BIT;
        end
      end
      CS_BIT: begin
        if (tick) begin
          unique case (ph_q)
            2'h0: sda_oe_d = !sh_q[8];
            2'h1: scl_oe_d = 1'b0;
            2'h2: begin
              rx_d = {rx_q[7:0], bus.sda};
              sh_d = {sh_q[7:0], 1'b1};
            end
            default: begin
              scl_oe_d = 1'b1;
              bit_d = bit_q + 4'h1;
              if (bit_q == 4'h8) begin
                bit_d = 4'h0;
                addrb_d = 1'b0;
                if ((addrb_q || !rdx_q) && rx_q[0]) begin
                  nack_d = 1'b1;
                  state_d = CS_STOP;
                end else if (!rdx_q) begin
                  fifo_pop = fifo_valid;
                  sh_d = {fifo_data, 1'b1};
                  state_d = fifo_valid ? CS_BIT : CS_STOP;
                end else if (addrb_q) begin
                  sh_d = {8'hff, len_q == 5'h01};
                end else begin
                  rxd_d = rx_q[8:1]; // RQ12
                  rxv_d = 1'b1;
                  len_d = len_next;
                  sh_d = {8'hff, len_next == 5'h01};
                  state_d = (len_next == 5'h00) ? CS_STOP : CS_HOLD;
                end
              end
            end
          endcase
        end
      end
      CS_HOLD: begin
        // scl stays low until software has taken the previous byte
        qcnt_d = 8'h00;
        ph_d = 2'h0;
        if (!rxv_q) state_d = CS_BIT;
      end
      CS_STOP: begin
        if (tick) begin
          unique case (ph_q)
            2'h0: sda_oe_d = 1'b1;
            2'h1: scl_oe_d = 1'b0;
            2'h2: sda_oe_d = 1'b0;
            default: state_d = CS_IDLE;
          endcase
        end
      end
      default: state_d = CS_IDLE;
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      state_q <= CS_IDLE;
      por_q <= 18'h00000;
      por_done_q <= 1'b0;
      first_q <= 1'b1;
      qcnt_q <= 8'h00;
      ph_q <= 2'h0;
      sh_q <= 9'h1ff;
      rx_q <= 9'h000;
      bit_q <= 4'h0;
      rdx_q <= 1'b0;
      addrb_q <= 1'b0;
      nack_q <= 1'b0;
      rxv_q <= 1'b0;
      len_q <= 5'h00;
      rxd_q <= 8'h00;
      scl_oe_q <= 1'b0;
      sda_oe_q <= 1'b0;
      rdata_q <= 32'h00000000;
    end else begin
      state_q <= state_d;
      por_q <= por_d;
      por_done_q <= por_done_d;
      first_q <= first_d;
      qcnt_q <= qcnt_d;
      ph_q <= ph_d;
      sh_q <= sh_d;
      rx_q <= rx_d;
      bit_q <= bit_d;
      rdx_q <= rdx_d;
      addrb_q <= addrb_d;
      nack_q <= nack_d;
      rxv_q <= rxv_d;
      len_q <= len_d;
      rxd_q <= rxd_d;
      scl_oe_q <= scl_oe_d;
      sda_oe_q <= sda_oe_d;
      rdata_q <= rdata_d;
    end
  end

  assign bus.ctl_scl_o = 1'b0;
  assign bus.ctl_sda_o = 1'b0;
  assign bus.ctl_scl_oe = scl_oe_q;
  assign bus.ctl_sda_oe = sda_oe_q;
  assign rdata = rdata_q;
endmodule : lcs_controller

// ### logic/lcs_defines.svh
// Purpose: shared constants of the lcd command sequencer, both ends
// Assumes: 200 MHz system clock on both ends
// Notes: times are kept in their own unit, cycle counts derive from them
`ifndef LCS_DEFINES_SVH
`define LCS_DEFINES_SVH

`define LCS_CLK_MHZ 200
// 7-bit bus identity: write byte 0x7c, read byte 0x7d
`define LCS_DEV_ID 7'h3e
`define LCS_RAM_LAST 6'h23
`define LCS_RAM_WORDS 36

// display defaults after power-up or soft reset
`define LCS_FRAME_DEF 2'h0
`define LCS_POWER_DEF 2'h2
`define LCS_BLINK_DEF 2'h0
`define LCS_PIXEL_DEF 2'h0

// controller timing
`define LCS_POR_MS 1
`define LCS_INIT_US 100
`define LCS_WAIT_CYC ((`LCS_POR_MS * 1000 + `LCS_INIT_US) * `LCS_CLK_MHZ)
`define LCS_QTR_NS 625
`define LCS_QTR_CYC ((`LCS_QTR_NS * `LCS_CLK_MHZ + 999) / 1000)

// controller register map (byte offsets) and fields
`define LCS_REG_CTRL 4'h0
`define LCS_REG_TXD 4'h4
`define LCS_REG_STAT 4'h8
`define LCS_REG_RXD 4'hc
`define LCS_CTRL_GO_WR 0
`define LCS_CTRL_GO_RD 1
`define LCS_CTRL_LEN_LSB 8
`define LCS_CTRL_LEN_MSB 12

`endif

// ### logic/lcs_device.sv
// Purpose: lcd driver end: bus target, command decoder and 36x4 display ram
// Assumes: scl and sda are synchronous to clk and much slower than it
// Notes: lcd waveform generation is outside this block
//
// Operation
// RQ1 - controller waits 100 us, then stop, start
// RQ2 - target answers write address byte 0x7c
// RQ3 - 0xEA soft resets, internal clock stays
// RQ4 - display control byte 0xBC sets lowest power
// RQ5 - 0xC8 enables display, one-third bias
// RQ6 - omitted display control keeps previous settings
// RQ7 - omitted blink byte keeps previous blink
// RQ8 - 0xE8 then 0x00 load ram pointer
// RQ9 - missing address msb byte means msb zero
// RQ10 - each data byte stored, pointer advances, 18 max
// RQ11 - read: set address, stop, then 0x7d
// RQ12 - read drives consecutive ram bytes until stop
// RQ13 - 0xC0 turns display off
// RQ14 - command bit7 one means another command follows
// RQ15 - two nibbles per byte, low address low
// RQ16 - no transfer during 1 ms power-up
// RQ17 - ack own writes, ignore others, stop on nack
`timescale 1ns/100ps
`include "lcs_defines.svh"
module lcs_device
  import lcs_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  lcs_if.dev bus,
  output logic display_on,
  output logic bias_half,
  output logic [1:0] frame_rate,
  output logic frame_inv,
  output logic [1:0] power_mode,
  output logic [1:0] blink_freq,
  output logic [1:0] pixel_mode,
  output logic clk_ext
);

  ////////////////////////////////////////////////////////////////////////////
  // state

  lcs_dev_state_type state_q, state_d;
  logic scl_q, sda_q;
  logic [7:0] shift_q, shift_d;
  logic [7:0] txsh_q, txsh_d;
  logic [3:0] cnt_q, cnt_d;
  logic addr_phase_q, addr_phase_d;
  logic rd_q, rd_d;
  logic cmd_mode_q, cmd_mode_d;
  logic a5_q, a5_d;
  logic [5:0] ptr_q, ptr_d;
  logic sda_oe_q, sda_oe_d;
  logic pin_lo_q;
  logic disp_q, disp_d;
  logic bias_q, bias_d;
  logic [1:0] frame_q, frame_d;
  logic finv_q, finv_d;
  logic [1:0] power_q, power_d;
  logic [1:0] blink_q, blink_d;
  logic [1:0] pixel_q, pixel_d;
  logic clk_ext_q, clk_ext_d;
  logic [3:0] ram_q [0:`LCS_RAM_WORDS-1];
  logic ram_we;
  logic tx_load;
  logic scl_rise, scl_fall, start_seen, stop_seen;
  logic [5:0] ptr_one, ptr_two, ptr_set;
  logic [7:0] tx_byte;

  // pointer wraps after the last ram word; out-of-range values restart at 0
  function automatic logic [5:0] lcs_next_addr(input logic [5:0] a);
    return (a >= `LCS_RAM_LAST) ? 6'h00 : a + 6'h01;
  endfunction : lcs_next_addr

  assign scl_rise = bus.scl && !scl_q;
  assign scl_fall = !bus.scl && scl_q;
  assign start_seen = bus.scl && scl_q && sda_q && !bus.sda;
  assign stop_seen = bus.scl && scl_q && !sda_q && bus.sda;
  assign ptr_one = lcs_next_addr(ptr_q);
  assign ptr_two = lcs_next_addr(ptr_one);
  assign ptr_set = ({a5_q, shift_q[4:0]} > `LCS_RAM_LAST) ? 6'h00 : {a5_q, shift_q[4:0]};
  assign tx_byte = {ram_q[ptr_one], ram_q[ptr_q]}; // RQ15

  ////////////////////////////////////////////////////////////////////////////
  // next state

  always_comb begin
    state_d = state_q;
    shift_d = shift_q;
    txsh_d = txsh_q;
    cnt_d = cnt_q;
    addr_phase_d = addr_phase_q;
    rd_d = rd_q;
    cmd_mode_d = cmd_mode_q;
    a5_d = a5_q;
    ptr_d = ptr_q;
    sda_oe_d = sda_oe_q;
    disp_d = disp_q;
    bias_d = bias_q;
    frame_d = frame_q;
    finv_d = finv_q;
    power_d = power_q;
    blink_d = blink_q;
    pixel_d = pixel_q;
    clk_ext_d = clk_ext_q;
    ram_we = 1'b0;
    tx_load = 1'b0;
    unique case (state_q)
      DS_IDLE: begin
      end
      DS_RX: begin
        if (scl_rise) begin
          shift_d = {shift_q[6:0], bus.sda};
          cnt_d = cnt_q + 4'h1;
        end
        if (scl_fall && cnt_q == 4'h8) begin
          cnt_d = 4'h0;
          state_d = DS_ACK;
          sda_oe_d = 1'b1; // RQ17
          if (addr_phase_q) begin
            addr_phase_d = 1'b0;
            rd_d = shift_q[0]; // RQ11
            if (shift_q[7:1] != `LCS_DEV_ID) begin // RQ2
              // foreign address: stay silent until the next start
              state_d = DS_IDLE; // RQ17
              sda_oe_d = 1'b0;
            end
          end else if (cmd_mode_q) begin
            cmd_mode_d = shift_q[7]; // RQ14
            // settings not named by a command keep their value
            casez (shift_q[6:0])
              7'b00?????: ptr_d = ptr_set; // RQ8 RQ9
              7'b01?????: begin // RQ4 RQ6
                frame_d = shift_q[4:3];
                finv_d = shift_q[2];
                power_d = shift_q[1:0];
              end
              7'b100????: begin // RQ5 RQ13
                disp_d = shift_q[3];
                bias_d = shift_q[2];
              end
              7'b1101???: begin
                a5_d = shift_q[2]; // RQ8
                clk_ext_d = shift_q[0];
                if (shift_q[1]) begin // RQ3
                  a5_d = 1'b0;
                  ptr_d = 6'h00;
                  disp_d = 1'b0;
                  bias_d = 1'b0;
                  frame_d = `LCS_FRAME_DEF;
                  finv_d = 1'b0;
                  power_d = `LCS_POWER_DEF;
                  blink_d = `LCS_BLINK_DEF;
                  pixel_d = `LCS_PIXEL_DEF;
                  clk_ext_d = 1'b0;
                end
              end
              7'b11100??: blink_d = shift_q[1:0]; // RQ7
              7'b11111??: pixel_d = shift_q[1:0];
              default: begin
              end
            endcase
          end else begin
            ram_we = 1'b1; // RQ10
            ptr_d = ptr_two; // RQ15
          end
        end
      end
      DS_ACK: begin
        if (scl_fall) begin
          sda_oe_d = 1'b0;
          state_d = DS_RX;
          tx_load = rd_q;
        end
      end
      DS_TX: begin
        if (scl_fall) begin
          if (cnt_q == 4'h8) begin
            sda_oe_d = 1'b0;
            state_d = DS_TXACK;
          end else begin
            txsh_d = {txsh_q[6:0], 1'b0};
            sda_oe_d = !txsh_q[6];
            cnt_d = cnt_q + 4'h1;
          end
        end
      end
      DS_TXACK: begin
        if (scl_rise && bus.sda) begin
          state_d = DS_IDLE; // RQ17
        end else if (scl_fall) begin
          tx_load = 1'b1; // RQ12
        end
      end
      default: state_d = DS_IDLE;
    endcase
    if (tx_load) begin
      // first bit goes out right on the falling edge
      state_d = DS_TX; // RQ12
      txsh_d = tx_byte;
      ptr_d = ptr_two; // RQ15
      sda_oe_d = !tx_byte[7];
      cnt_d = 4'h1;
    end
    if (start_seen) begin
      state_d = DS_RX;
      addr_phase_d = 1'b1;
      cmd_mode_d = 1'b1;
      a5_d = 1'b0; // RQ9
      cnt_d = 4'h0;
      sda_oe_d = 1'b0;
    end else if (stop_seen) begin
      state_d = DS_IDLE;
      sda_oe_d = 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // registers

  always_ff @(posedge clk) begin
    if (rst) begin
      state_q <= DS_IDLE;
      scl_q <= 1'b1;
      sda_q <= 1'b1;
      shift_q <= 8'h00;
      txsh_q <= 8'h00;
      cnt_q <= 4'h0;
      addr_phase_q <= 1'b0;
      rd_q <= 1'b0;
      cmd_mode_q <= 1'b1;
      a5_q <= 1'b0;
      ptr_q <= 6'h00;
      sda_oe_q <= 1'b0;
      pin_lo_q <= 1'b0;
      disp_q <= 1'b0;
      bias_q <= 1'b0;
      frame_q <= `LCS_FRAME_DEF;
      finv_q <= 1'b0;
      power_q <= `LCS_POWER_DEF;
      blink_q <= `LCS_BLINK_DEF;
      pixel_q <= `LCS_PIXEL_DEF;
      clk_ext_q <= 1'b0;
    end else begin
      state_q <= state_d;
      scl_q <= bus.scl;
      sda_q <= bus.sda;
      shift_q <= shift_d;
      txsh_q <= txsh_d;
      cnt_q <= cnt_d;
      addr_phase_q <= addr_phase_d;
      rd_q <= rd_d;
      cmd_mode_q <= cmd_mode_d;
      a5_q <= a5_d;
      ptr_q <= ptr_d;
      sda_oe_q <= sda_oe_d;
      pin_lo_q <= 1'b0;
      disp_q <= disp_d;
      bias_q <= bias_d;
      frame_q <= frame_d;
      finv_q <= finv_d;
      power_q <= power_d;
      blink_q <= blink_d;
      pixel_q <= pixel_d;
      clk_ext_q <= clk_ext_d;
    end
  end

  // display ram holds data only, so it is not cleared by reset
  always_ff @(posedge clk) begin
    if (ram_we && ptr_q <= `LCS_RAM_LAST) begin
      ram_q[ptr_q] <= shift_q[3:0]; // RQ15
      ram_q[ptr_one] <= shift_q[7:4];
    end
  end

  assign bus.dev_sda_o = pin_lo_q;
  assign bus.dev_sda_oe = sda_oe_q;
  assign display_on = disp_q;
  assign bias_half = bias_q;
  assign frame_rate = frame_q;
  assign frame_inv = finv_q;
  assign power_mode = power_q;
  assign blink_freq = blink_q;
  assign pixel_mode = pixel_q;
  assign clk_ext = clk_ext_q;

endmodule : lcs_device

// ### logic/lcs_if.sv
// Purpose: two-wire bus joining the controller and the lcd driver
// Assumes: open-drain wires with pull-ups; an enable pulls the wire low
// Notes: scl is driven by the controller only
`timescale 1ns/100ps
interface lcs_if;
  logic ctl_scl_o;
  logic ctl_scl_oe;
  logic ctl_sda_o;
  logic ctl_sda_oe;
  logic dev_sda_o;
  logic dev_sda_oe;
  logic scl;
  logic sda;

  // wired-and of every driver, idle high
  assign scl = !(ctl_scl_oe && !ctl_scl_o);
  assign sda = !(ctl_sda_oe && !ctl_sda_o) && !(dev_sda_oe && !dev_sda_o);

  modport ctl (output ctl_scl_o, output ctl_scl_oe, output ctl_sda_o, output ctl_sda_oe,
               input scl, input sda);
  modport dev (output dev_sda_o, output dev_sda_oe, input scl, input sda);
endinterface : lcs_if

// ### logic/lcs_pkg.sv
// Purpose: state types of both ends of the lcd command sequencer
// Assumes: constants live in lcs_defines.svh
// Notes: none
package lcs_pkg;

  typedef enum logic [2:0] {DS_IDLE, DS_RX, DS_ACK, DS_TX, DS_TXACK} lcs_dev_state_type;

  typedef enum logic [2:0] {
    CS_IDLE, CS_PSTOP, CS_START, CS_BIT, CS_HOLD, CS_STOP
  } lcs_ctl_state_type;

endpackage : lcs_pkg

// ### tb/lcs_assertions.sv
// Purpose: wire checks on the two-wire bus joining both ends
// Assumes: POR_CYC equals the controller's value
// Notes: start, stop and bit slots are decoded from the resolved wires
`timescale 1ns/100ps
module lcs_assertions #(
  parameter int POR_CYC = 50
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic ctl_scl_oe,
  input wire logic ctl_sda_oe,
  input wire logic dev_sda_oe,
  input wire logic scl,
  input wire logic sda
);
  logic scl_q, sda_q, stop_seen_q, first_q, read_q;
  logic [3:0] cnt_q;
  logic [7:0] sh_q;
  logic [31:0] cyc_q;
  logic rise, start, ack_slot;

  assign rise = scl && !scl_q;
  assign start = scl && scl_q && sda_q && !sda;
  assign ack_slot = rise && (cnt_q == 4'h8);

  //////////////////////////////////////////////////
  // a start restarts the slot count wherever it falls
  always_ff @(posedge clk) begin
    if (rst) begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
      stop_seen_q <= 1'b0;
      first_q <= 1'b1;
      read_q <= 1'b0;
      cnt_q <= 4'h0;
      sh_q <= 8'h00;
      cyc_q <= 32'h0;
    end else begin
      scl_q <= scl;
      sda_q <= sda;
      if (cyc_q < 32'(POR_CYC)) cyc_q <= cyc_q + 32'h1;
      if (scl && scl_q && !sda_q && sda) stop_seen_q <= 1'b1;
      if (start) begin
        cnt_q <= 4'h0;
        first_q <= 1'b1;
      end else if (ack_slot) begin
        cnt_q <= 4'h0;
        first_q <= 1'b0;
        if (first_q) read_q <= sh_q[0];
      end else if (rise) begin
        cnt_q <= cnt_q + 4'h1;
        sh_q <= {sh_q[6:0], sda};
      end
    end
  end

  //////////////////////////////////////////////////
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  por_wait_a: assert property ((ctl_scl_oe || ctl_sda_oe) |-> cyc_q >= 32'(POR_CYC))
    else $error("bus active during power-up wait");
  stop_first_a: assert property (start |-> stop_seen_q)
    else $error("start without a preceding stop");
  write_ack_a: assert property ((ack_slot && first_q && sh_q == 8'h7c) |-> !sda && dev_sda_oe)
    else $error("write address not acknowledged");
  read_ack_a: assert property ((ack_slot && first_q && sh_q == 8'h7d) |-> dev_sda_oe)
    else $error("read address not acknowledged");
  data_ack_a: assert property ((ack_slot && !first_q && !read_q) |-> dev_sda_oe)
    else $error("write byte not acknowledged");
  read_release_a: assert property ((ack_slot && !first_q && read_q) |-> !dev_sda_oe)
    else $error("device holds sda in controller ack slot");
  dev_stable_a: assert property ((scl && scl_q) |-> $stable(dev_sda_oe))
    else $error("device sda moved while scl high");
  dev_launch_a: assert property ($rose(dev_sda_oe) |-> !scl && !scl_q)
    else $error("device drive began outside scl low");
endmodule : lcs_assertions

// ### tb/test_lcd_i2c_command_sequencer.sv
// Purpose: register-level test of controller and lcd driver end
// Assumes: power-up wait shortened to 50 cycles
// Notes: every transfer crosses the real bus between the two ends
`timescale 1ns/100ps
`include "lcs_defines.svh"
module test_lcd_i2c_command_sequencer;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [3:0] addr = 4'h0;
  logic [31:0] wdata = 32'h0;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [31:0] rdata, v;
  logic tx_ready, display_on, bias_half, frame_inv, clk_ext;
  logic [1:0] frame_rate, power_mode, blink_freq, pixel_mode;
  logic [11:0] outs;
  logic [7:0] q_init[$] = '{8'hea, 8'hbc, 8'hf1, 8'hc8};
  logic [7:0] q_rd[$] = '{8'h3c, 8'h96};
  int err_total = 0;
  int checks = 0;

  always #2.5 clk = ~clk;
  assign outs = {display_on, bias_half, frame_rate, frame_inv, power_mode, blink_freq,
                 pixel_mode, clk_ext};

  lcs_if bus_if ();
  lcs_controller #(.POR_CYC(50)) lcs_controller_inst (.clk(clk), .rst(rst), .bus(bus_if),
    .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .tx_ready(tx_ready));
  lcs_device lcs_device_inst (.clk(clk), .rst(rst), .bus(bus_if), .display_on(display_on),
    .bias_half(bias_half), .frame_rate(frame_rate), .frame_inv(frame_inv),
    .power_mode(power_mode), .blink_freq(blink_freq), .pixel_mode(pixel_mode),
    .clk_ext(clk_ext));
  lcs_assertions #(.POR_CYC(50)) lcs_assertions_inst (.clk(clk), .rst(rst),
    .ctl_scl_oe(bus_if.ctl_scl_oe), .ctl_sda_oe(bus_if.ctl_sda_oe),
    .dev_sda_oe(bus_if.dev_sda_oe), .scl(bus_if.scl), .sda(bus_if.sda));

  //////////////////////////////////////////////////
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", checks, err_total);
    if (err_total == 0 && checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : end_of_test

  task automatic chk_reg(input string name, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp) begin
      err_total++;
      $display("MISMATCH %s expected %h seen %h", name, exp, got);
    end
  endtask : chk_reg

  task automatic chk_out(input string name, input logic [11:0] exp);
    checks++;
    if (outs !== exp) begin
      err_total++;
      $display("MISMATCH %s expected %h seen %h", name, exp, outs);
    end
  endtask : chk_out

  task automatic wr_reg(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask : wr_reg

  task automatic rd_reg(input logic [3:0] a, output logic [31:0] d);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    @(posedge clk);
    d = rdata;
  endtask : rd_reg

  // polls status; a bound that runs out closes the run
  task automatic wait_stat(input logic [31:0] m, input logic [31:0] e);
    for (int i = 0; i < 12000; i++) begin
      rd_reg(`LCS_REG_STAT, v);
      if ((v & m) === e) return;
    end
    err_total++;
    $display("MISMATCH status wait expected %h seen %h", e, v & m);
    end_of_test();
  endtask : wait_stat

  task automatic finish_xfer(input logic [31:0] m);
    wait_stat(32'h1, 32'h1);
    wait_stat(m, 32'h0);
  endtask : finish_xfer

  // more than four bytes: go after the fourth, the rest follow as room appears
  task automatic send(input logic [7:0] q[$]);
    foreach (q[i]) begin
      if (i == 4) wr_reg(`LCS_REG_CTRL, 32'h1);
      wait_stat(32'h8, 32'h8);
      wr_reg(`LCS_REG_TXD, {24'h0, q[i]});
    end
    if (q.size() <= 4) wr_reg(`LCS_REG_CTRL, 32'h1);
    finish_xfer(32'h3);
  endtask : send

  //////////////////////////////////////////////////
  initial begin
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    // go inside the power-up wait must be ignored
    wr_reg(`LCS_REG_CTRL, 32'h1);
    rd_reg(`LCS_REG_STAT, v);
    chk_reg("status after reset", 32'h8, v);
    chk_out("defaults", 12'h040);
    rd_reg(4'h2, v);
    chk_reg("unmapped read", 32'h0, v);
    wait_stat(32'h10, 32'h10);
    foreach (q_init[i]) wr_reg(`LCS_REG_TXD, {24'h0, q_init[i]});
    rd_reg(`LCS_REG_STAT, v);
    chk_reg("fifo full status", 32'h10, v & 32'h18);
    chk_reg("tx ready pin", 32'h0, {31'h0, tx_ready});
    // refused while full: would switch the display off if taken
    wr_reg(`LCS_REG_TXD, 32'hc0);
    wr_reg(`LCS_REG_CTRL, 32'h1);
    finish_xfer(32'h3);
    chk_out("after init", 12'hb88);
    send('{8'hec, 8'h02, 8'h5a, 8'h3c, 8'h96});
    chk_out("settings kept", 12'hb88);
    send('{8'h00});
    wr_reg(`LCS_REG_CTRL, 32'h202);
    foreach (q_rd[i]) begin
      wait_stat(32'h4, 32'h4);
      rd_reg(`LCS_REG_RXD, v);
      chk_reg("read byte", {24'h0, q_rd[i]}, v);
    end
    wait_stat(32'h1, 32'h0);
    // clock source and all-pixel bytes ride along before the display off byte
    send('{8'he9, 8'hfd, 8'hc0});
    chk_out("display off", 12'h38b);
    end_of_test();
  end
endmodule : test_lcd_i2c_command_sequencer
